// File: common/mbs_pkg.sv
//
// Overview of operation
// - Each serial character is one start bit, eight data bits and no parity bit.
// - Transmitted characters carry two stop bits; received ones may carry one or two.
// - The bit rate is selectable from 1200 to 115200 bit/s, equal on both ends.
// - Frames follow Modbus RTU rules, the block acting as a slave of holding registers.
// - Register contents are signed two's complement 16-bit words.
// - Function 03h returns one register or a contiguous group of registers.
// - Function 06h writes one register, 10h a contiguous group, with the standard reply.
// - Broadcast frames are executed but never answered.
// - The rate setting picks one of 1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200.
// - With the write lock on, serial writes are refused except to registers 04h and 05h.
// - A gap between frames longer than the 0..99 s timeout (0 = off) forces relay alert.
// - Each reply waits an extra 0, 10, 20, 50, 100 or 200 character times.
//
package mbs_pkg;
	// ----------------------------------------------------------------
	// clocking and serial timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
	localparam int CHAR_BITS     = 11;          // start, 8 data, 2 stop
	localparam int T35_BITS      = 39;          // 3.5 chars, rounded up
	localparam int GAP_UNIT_NS   = 1_000_000_000;
	localparam int GAP_UNIT_CYC  = GAP_UNIT_NS / CLK_PERIOD_NS;
	localparam logic [6:0] GAP_MAX_S = 7'h63;

	// bit period in clocks per rate code
	localparam logic [16:0] BIT_CYC [8] = '{
		17'(CLK_HZ / 1200),  17'(CLK_HZ / 2400),  17'(CLK_HZ / 4800),
		17'(CLK_HZ / 9600),  17'(CLK_HZ / 19200), 17'(CLK_HZ / 38400),
		17'(CLK_HZ / 57600), 17'(CLK_HZ / 115200)};
	// extra reply delay in characters per delay code
	localparam logic [7:0] DLY_CHARS [8] = '{
		8'h00, 8'h0a, 8'h14, 8'h32, 8'h64, 8'hc8, 8'h00, 8'h00};

	// ----------------------------------------------------------------
	// protocol
	// ----------------------------------------------------------------
	localparam int          NREG      = 64;
	localparam int          BUF_BYTES = 48;
	localparam logic [15:0] MAX_QTY   = 16'h0010;
	localparam logic [7:0]  BCAST     = 8'h00;
	localparam logic [7:0]  FN_RD     = 8'h03;
	localparam logic [7:0]  FN_WR1    = 8'h06;
	localparam logic [7:0]  FN_WRN    = 8'h10;
	localparam logic [7:0]  EXC_FLAG  = 8'h80;
	localparam logic [7:0]  EX_FUNC   = 8'h01;
	localparam logic [7:0]  EX_ADDR   = 8'h02;
	localparam logic [7:0]  EX_VAL    = 8'h03;
	localparam logic [15:0] RELAY_REG = 16'h0004;
	localparam logic [15:0] RELAY_NB  = 16'h0005;
	localparam logic [15:0] CRC_INIT  = 16'hffff;
	localparam logic [15:0] CRC_POLY  = 16'ha001;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] A_CTRL    = 12'h000;
	localparam logic [11:0] A_GAP     = 12'h004;
	localparam logic [11:0] A_STAT    = 12'h008;
	localparam logic [11:0] A_ID      = 12'h00c;
	localparam logic [3:0]  HREG_PAGE = 4'h1;
	localparam int CTRL_BAUD_LSB = 0;
	localparam int CTRL_DLY_LSB  = 4;
	localparam int CTRL_LOCK_BIT = 8;
	localparam int CTRL_ADDR_LSB = 16;
	localparam logic [31:0] CTRL_RST = 32'h0001_0003;
	localparam logic [1:0]  REPLY_EXTRA_DELAY_OK  = 2'h0;
	localparam logic [1:0]  REPLY_EXTRA_DELAY_ERR = 2'h2;

	typedef enum logic [2:0] {ST_RX, ST_CHECK, ST_EXEC, ST_WAIT, ST_SEND, ST_DRAIN} mbs_state_e;

	// one byte step of the reflected frame check code
	function automatic logic [15:0] mbs_crc(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int k = 0; k < 8; k++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction
endpackage

// File: design/mbs_uart_rx.sv
`timescale 1ns/1ps
`default_nettype none
module mbs_uart_rx
	import mbs_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [16:0] bit_cyc,
	input  wire logic        rxd,
	output logic             busy,
	output logic             done,
	output logic             err,
	output logic [7:0]       data
);
	logic        s1_q, s2_q, s3_q, rx_q;
	logic [3:0]  nb_q;
	logic [16:0] cnt_q;

	// three-stage sync, level accepted once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{s1_q, s2_q, s3_q, rx_q} <= 4'hf;
		end else if (ce) begin
			s1_q <= rxd;
			s2_q <= s1_q;
			s3_q <= s2_q;
			rx_q <= (s2_q == s3_q) ? s3_q : rx_q;
		end
	end

	// start, 8 data lsb first, one stop sampled mid-bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy  <= 1'b0;
			done  <= 1'b0;
			err   <= 1'b0;
			nb_q  <= 4'h0;
			cnt_q <= 17'h0;
			data  <= 8'h00;
		end else if (ce) begin
			done <= 1'b0;
			err  <= 1'b0;
			if (!busy) begin
				if (!rx_q) begin
					busy  <= 1'b1;
					nb_q  <= 4'h0;
					cnt_q <= bit_cyc >> 1;
				end
			end else if (cnt_q != 17'h0) begin
				cnt_q <= cnt_q - 17'h1;
			end else begin
				cnt_q <= bit_cyc - 17'h1;
				nb_q  <= nb_q + 4'h1;
				if (nb_q == 4'h0) begin
					busy <= ~rx_q;              // glitch, not a start
				end else if (nb_q != 4'h9) begin
					data <= {rx_q, data[7:1]};
				end else begin
					busy <= 1'b0;               // second stop bit is just idle
					done <= rx_q;
					err  <= ~rx_q;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: design/mbs_uart_tx.sv
`timescale 1ns/1ps
`default_nettype none
module mbs_uart_tx
	import mbs_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [16:0] bit_cyc,
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic [7:0]  in_data,
	output logic             txd,
	output logic             de
);
	logic [10:0] sh_q;
	logic [3:0]  nb_q;
	logic [16:0] cnt_q;

	assign in_ready = ce & ~de;
	assign txd      = sh_q[0];

	// shifts start, 8 data, two stop bits; idle line stays high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sh_q  <= 11'h7ff;
			nb_q  <= 4'h0;
			cnt_q <= 17'h0;
			de    <= 1'b0;
		end else if (ce) begin
			if (in_valid && !de) begin
				sh_q  <= {2'h3, in_data, 1'b0};
				nb_q  <= 4'(CHAR_BITS - 1);
				cnt_q <= 17'h0;
				de    <= 1'b1;
			end else if (de) begin
				if (cnt_q >= bit_cyc - 17'h1) begin
					cnt_q <= 17'h0;
					sh_q  <= {1'b1, sh_q[10:1]};
					nb_q  <= nb_q - 4'h1;
					de    <= (nb_q != 4'h0);
				end else begin
					cnt_q <= cnt_q + 17'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: design/mbs_slave.sv
`timescale 1ns/1ps
`default_nettype none
module mbs_slave
	import mbs_pkg::*;
#(
	parameter int          SEC_CYC = GAP_UNIT_CYC,
	parameter logic [15:0] ID_CODE = 16'h5a5a // arbitrary value
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        rs485_rxd,
	output logic             rs485_txd,
	output logic             rs485_de,
	output logic             relay_a,
	output logic             relay_b,
	output logic             gap_alert
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q;
	logic [6:0]  gap_q;
	logic [15:0] hreg_q [NREG];
	logic [7:0]  fbuf_q [BUF_BYTES];
	logic [5:0]  len_q;
	logic        ovf_q;
	logic [15:0] crc_q;
	mbs_state_e  st_q;
	logic [7:0]  exc_q;
	logic [4:0]  n_q;
	logic [4:0]  i_q;
	logic [6:0]  plen_q;
	logic [6:0]  sidx_q;
	logic [11:0] wcnt_q;
	logic        bcast_q;
	logic [7:0]  sil_q;
	logic [16:0] bdiv_q;
	logic [31:0] scyc_q;
	logic [6:0]  secs_q;

	// ----------------------------------------------------------------
	// settings and serial ends
	// ----------------------------------------------------------------
	wire logic [2:0]  baud_sel = ctrl_q[CTRL_BAUD_LSB +: 3];
	wire logic [2:0]  dly_sel  = ctrl_q[CTRL_DLY_LSB +: 3];
	wire logic        wr_lock  = ctrl_q[CTRL_LOCK_BIT];
	wire logic [7:0]  own_addr = ctrl_q[CTRL_ADDR_LSB +: 8];
	wire logic [16:0] bit_cyc  = BIT_CYC[baud_sel];
	wire logic        tick     = (bdiv_q >= bit_cyc - 17'h1);
	wire logic [11:0] wtgt     = 12'(DLY_CHARS[dly_sel]) * 12'(CHAR_BITS);

	logic       rx_busy, rx_done, rx_err, tx_ready;
	logic [7:0] rx_data, tx_byte;
	wire logic  tx_valid = (st_q == ST_SEND);

	mbs_uart_rx u_rx (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.bit_cyc (bit_cyc),
		.rxd     (rs485_rxd),
		.busy    (rx_busy),
		.done    (rx_done),
		.err     (rx_err),
		.data    (rx_data)
	);

	mbs_uart_tx u_tx (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ce       (ce),
		.bit_cyc  (bit_cyc),
		.in_valid (tx_valid),
		.in_ready (tx_ready),
		.in_data  (tx_byte),
		.txd      (rs485_txd),
		.de       (rs485_de)
	);

	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------
	wire logic [7:0]  fn     = fbuf_q[1];
	wire logic [15:0] start  = {fbuf_q[2], fbuf_q[3]};
	wire logic [15:0] qty    = {fbuf_q[4], fbuf_q[5]};
	wire logic        is_rd  = (fn == FN_RD);
	wire logic        is_w1  = (fn == FN_WR1);
	wire logic        is_wn  = (fn == FN_WRN);
	wire logic        is_wr  = is_w1 | is_wn;
	wire logic [16:0] nq     = is_w1 ? 17'h1 : {1'b0, qty};
	wire logic [16:0] endreg = {1'b0, start} + nq;
	wire logic        short  = is_wn && ({11'h0, len_q} < (endreg - {1'b0, start}) * 17'h2 + 17'h9);
	wire logic        qty_bad = ((is_rd | is_wn) && (qty == 16'h0 || qty > MAX_QTY)) || short;
	wire logic        rng_bad = endreg > 17'(NREG);
	wire logic        lck_bad = is_wr && wr_lock &&
		!(start >= RELAY_REG && endreg <= {1'b0, RELAY_NB} + 17'h1);
	wire logic [7:0]  exc_d  = !(is_rd | is_wr) ? EX_FUNC :
		qty_bad ? EX_VAL : (rng_bad | lck_bad) ? EX_ADDR : 8'h00;
	wire logic        to_me  = (fbuf_q[0] == own_addr) || (fbuf_q[0] == BCAST);
	wire logic        frame_ok = (crc_q == 16'h0) && (len_q >= 6'h4) && !ovf_q && to_me;
	wire logic        frame_end = (st_q == ST_RX) && (len_q != 6'h0) && !rx_busy &&
		(sil_q >= 8'(T35_BITS));
	wire logic        good_frame = (st_q == ST_CHECK) && frame_ok;

	// ----------------------------------------------------------------
	// reply byte selection
	// ----------------------------------------------------------------
	wire logic [6:0]  sj     = sidx_q - 7'h3;
	wire logic [15:0] rreg   = hreg_q[6'(start[5:0] + {1'b0, sj[5:1]})];
	wire logic [7:0]  rdbyte = sj[0] ? rreg[7:0] : rreg[15:8];
	wire logic [7:0]  body   = (sidx_q == 7'h2) ? {2'h0, n_q, 1'b0} : rdbyte;
	wire logic [7:0]  pbyte  = (sidx_q == 7'h0) ? fbuf_q[0] :
		(sidx_q == 7'h1) ? ((exc_q != 8'h0) ? (fn | EXC_FLAG) : fn) :
		(exc_q != 8'h0) ? exc_q : is_rd ? body : fbuf_q[sidx_q[5:0]];
	assign tx_byte = (sidx_q < plen_q) ? pbyte :
		(sidx_q == plen_q) ? crc_q[7:0] : crc_q[15:8];

	wire logic       eng_wr = (st_q == ST_EXEC);
	wire logic [5:0] ew_idx = 6'(start[5:0] + {1'b0, i_q});
	wire logic [5:0] ew_lo  = 6'(6'h7 + {i_q, 1'b0});
	wire logic [15:0] ew_val = is_w1 ? qty : {fbuf_q[ew_lo], fbuf_q[6'(ew_lo + 6'h1)]};

	// bit-time ticker for silence and reply delay
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bdiv_q <= 17'h0;
			sil_q  <= 8'h0;
		end else if (ce) begin
			bdiv_q <= tick ? 17'h0 : bdiv_q + 17'h1;
			if (rx_busy || rx_done)
				sil_q <= 8'h0;
			else if (tick && sil_q != 8'hff)
				sil_q <= sil_q + 8'h1;
		end
	end

	// ----------------------------------------------------------------
	// frame engine
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q    <= ST_RX;
			len_q   <= 6'h0;
			ovf_q   <= 1'b0;
			crc_q   <= CRC_INIT;
			exc_q   <= 8'h00;
			n_q     <= 5'h0;
			i_q     <= 5'h0;
			plen_q  <= 7'h0;
			sidx_q  <= 7'h0;
			wcnt_q  <= 12'h0;
			bcast_q <= 1'b0;
		end else if (ce) begin
			unique case (st_q)
				ST_RX: begin
					if (rx_err) begin
						ovf_q <= 1'b1;
					end else if (rx_done) begin
						if (len_q == 6'(BUF_BYTES)) begin
							ovf_q <= 1'b1;
						end else begin
							fbuf_q[len_q] <= rx_data;
							len_q <= len_q + 6'h1;
							crc_q <= mbs_crc(crc_q, rx_data);
						end
					end else if (frame_end) begin
						st_q <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					exc_q   <= exc_d;
					n_q     <= nq[4:0];
					i_q     <= 5'h0;
					wcnt_q  <= 12'h0;
					bcast_q <= (fbuf_q[0] == BCAST);
					plen_q  <= (exc_d != 8'h0) ? 7'h3 : is_rd ? 7'(7'h3 + {nq[4:0], 1'b0}) : 7'h6;
					if (!frame_ok) begin
						st_q <= ST_RX;
					end else if (exc_d == 8'h0 && is_wr) begin
						st_q <= ST_EXEC;
					end else begin
						st_q <= (fbuf_q[0] == BCAST) ? ST_RX : ST_WAIT;
					end
				end
				ST_EXEC: begin
					i_q <= i_q + 5'h1;
					if (i_q == n_q - 5'h1)
						st_q <= bcast_q ? ST_RX : ST_WAIT;
				end
				ST_WAIT: begin
					if (wcnt_q >= wtgt) begin
						st_q   <= ST_SEND;
						sidx_q <= 7'h0;
						crc_q  <= CRC_INIT;
					end else if (tick) begin
						wcnt_q <= wcnt_q + 12'h1;
					end
				end
				ST_SEND: begin
					if (tx_ready) begin
						sidx_q <= sidx_q + 7'h1;
						if (sidx_q < plen_q)
							crc_q <= mbs_crc(crc_q, pbyte);
						if (sidx_q == plen_q + 7'h1)
							st_q <= ST_DRAIN;
					end
				end
				ST_DRAIN: begin
					if (tx_ready)
						st_q <= ST_RX;
				end
			endcase
			if (st_q != ST_RX) begin // bytes heard while busy are dropped
				len_q <= 6'h0;
				ovf_q <= 1'b0;
				if (st_q == ST_CHECK || st_q == ST_DRAIN)
					crc_q <= CRC_INIT;
			end
		end
	end

	// frame gap watchdog, cleared by each good frame
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scyc_q    <= 32'h0;
			secs_q    <= 7'h0;
			gap_alert <= 1'b0;
			relay_a   <= 1'b0;
			relay_b   <= 1'b0;
		end else if (ce) begin
			if (good_frame) begin
				scyc_q <= 32'h0;
				secs_q <= 7'h0;
			end else if (scyc_q == 32'(SEC_CYC - 1)) begin
				scyc_q <= 32'h0;
				secs_q <= (secs_q == 7'h7f) ? secs_q : secs_q + 7'h1;
			end else begin
				scyc_q <= scyc_q + 32'h1;
			end
			gap_alert <= (gap_q != 7'h0) && (secs_q > gap_q);
			relay_a   <= hreg_q[RELAY_REG[5:0]][0] & ~(gap_q != 7'h0 && secs_q > gap_q);
			relay_b   <= hreg_q[RELAY_REG[5:0]][1] & ~(gap_q != 7'h0 && secs_q > gap_q);
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	logic        awv_q, wv_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;

	assign s_axi_awready = ce & ~awv_q;
	assign s_axi_wready  = ce & ~wv_q;
	assign s_axi_arready = ce & ~s_axi_rvalid;

	wire logic        do_wr  = ce && awv_q && wv_q && !s_axi_bvalid && !eng_wr;
	wire logic [31:0] wmask  = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire logic        aw_hreg = (awaddr_q[11:8] == HREG_PAGE);
	wire logic [5:0]  aw_idx = awaddr_q[7:2];
	wire logic        aw_ctrl = (awaddr_q == A_CTRL);
	wire logic        aw_gap  = (awaddr_q == A_GAP);
	wire logic        aw_ok   = aw_hreg || aw_ctrl || aw_gap;
	wire logic [31:0] old_w   = aw_ctrl ? ctrl_q : aw_gap ? {25'h0, gap_q} :
		{16'h0, hreg_q[aw_idx]};
	wire logic [31:0] new_w   = (old_w & ~wmask) | (wdata_q & wmask);
	wire logic        ar_hreg = (s_axi_araddr[11:8] == HREG_PAGE);
	wire logic        ar_ok   = ar_hreg || s_axi_araddr == A_CTRL || s_axi_araddr == A_GAP ||
		s_axi_araddr == A_STAT || s_axi_araddr == A_ID;
	wire logic [31:0] ar_val  = ar_hreg ? {16'h0, hreg_q[s_axi_araddr[7:2]]} :
		(s_axi_araddr == A_CTRL) ? ctrl_q :
		(s_axi_araddr == A_GAP) ? {25'h0, gap_q} :
		(s_axi_araddr == A_STAT) ? {21'h0, secs_q, st_q, gap_alert} :
		(s_axi_araddr == A_ID) ? {16'h0, ID_CODE} : 32'h0;

	// write and read channels, one of each outstanding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awv_q        <= 1'b0;
			wv_q         <= 1'b0;
			awaddr_q     <= 12'h0;
			wdata_q      <= 32'h0;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= REPLY_EXTRA_DELAY_OK;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= REPLY_EXTRA_DELAY_OK;
			s_axi_rdata  <= 32'h0;
			ctrl_q       <= CTRL_RST;
			gap_q        <= 7'h0;
		end else if (ce) begin
			if (s_axi_awvalid && !awv_q) begin
				awv_q    <= 1'b1;
				awaddr_q <= {s_axi_awaddr[11:2], 2'h0};
			end
			if (s_axi_wvalid && !wv_q) begin
				wv_q    <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_wr) begin
				awv_q        <= 1'b0;
				wv_q         <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= aw_ok ? REPLY_EXTRA_DELAY_OK : REPLY_EXTRA_DELAY_ERR;
				if (aw_ctrl)
					ctrl_q <= new_w;
				if (aw_gap)
					gap_q <= (new_w[31:0] > 32'(GAP_MAX_S)) ? GAP_MAX_S : new_w[6:0];
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= ar_val;
				s_axi_rresp  <= ar_ok ? REPLY_EXTRA_DELAY_OK : REPLY_EXTRA_DELAY_ERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// holding registers: serial writes first, bus writes when idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int k = 0; k < NREG; k++)
				hreg_q[k] <= 16'h0;
		end else if (ce) begin
			if (eng_wr)
				hreg_q[ew_idx] <= ew_val;
			else if (do_wr && aw_hreg)
				hreg_q[aw_idx] <= new_w[15:0];
		end
	end
endmodule
`default_nettype wire

// File: test/mbs_slave_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// port checker for the serial register slave
// ------------------------------------------------
module mbs_slave_chk
	import mbs_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        rs485_txd,
	input wire logic        rs485_de,
	input wire logic        relay_a,
	input wire logic        relay_b,
	input wire logic        gap_alert
);
	localparam int MIN_BIT = int'(BIT_CYC[7]);
	logic [31:0] de_cnt_q;
	logic [31:0] hi_cnt_q;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// cycles with driver on, and with the line high under it
	always_ff @(posedge aclk) begin
		de_cnt_q <= rs485_de ? de_cnt_q + 32'h1 : '0;
		hi_cnt_q <= (rs485_de && rs485_txd) ? hi_cnt_q + 32'h1 : '0;
	end

	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence

	relay_forced_a: assert property (gap_alert |-> !relay_a && !relay_b)
		else $error("relay on during gap alert");
	idle_high_a: assert property (!rs485_de |-> rs485_txd)
		else $error("line low with driver off");
	start_low_a: assert property ($rose(rs485_de) |-> !rs485_txd)
		else $error("character without start bit");
	two_stop_a: assert property ($fell(rs485_de) |-> hi_cnt_q >= 2 * MIN_BIT - 2)
		else $error("fewer than two stop bits");
	char_len_a: assert property ($fell(rs485_de) |-> de_cnt_q >= 11 * MIN_BIT - 2)
		else $error("driver on shorter than a character");
	rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
		else $error("read answer late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("second read taken");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	wr_block_a: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready))
		else $error("write answered while address stage open");
endmodule

bind mbs_slave mbs_slave_chk mbs_slave_chk_inst (.aclk, .aresetn, .s_axi_awready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .rs485_txd, .rs485_de, .relay_a, .relay_b, .gap_alert);
`default_nettype wire

// File: test/mbs_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// remote bus master at 115200 bit/s
// ------------------------------------------------
module mbs_master_model
	import mbs_pkg::*;
(
	input wire logic aclk,
	output logic     rxd,
	input wire logic txd,
	input wire logic de
);
	localparam int BIT = int'(BIT_CYC[7]); // same rate as the slave

	// reflected check code over a byte queue
	function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		return c;
	endfunction

	// biased bus rests high between frames
	initial rxd = 1'b1;

	// start, eight data lsb first, one stop only, no parity
	task automatic put_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge aclk);
		end
	endtask

	// whole frame, check code low byte first
	task automatic send(input logic [7:0] b[$]);
		logic [15:0] c;
		c = crc_of(b);
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		foreach (b[i])
			put_byte(b[i]);
	endtask

	// one reply character; ok low if a stop bit or the driver is missing
	task automatic get_byte(output logic [7:0] b, output logic ok);
		ok = 1'b1;
		while (txd !== 1'b0)
			@(posedge aclk);
		repeat (BIT / 2) @(posedge aclk);
		for (int i = 0; i < 10; i++) begin
			repeat (BIT) @(posedge aclk);
			if (i < 8)
				b[i] = txd;
			else if (txd !== 1'b1 || de !== 1'b1)
				ok = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// File: test/mbs_slave_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
// ------------------------------------------------
// bench for the serial register slave
// ------------------------------------------------
module mbs_slave_test
	import mbs_pkg::*;
;
	localparam int          SEC   = 1000;
	localparam int          BIT   = int'(BIT_CYC[7]);
	localparam logic [15:0] IDV   = 16'h1234; // arbitrary value
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        aclk, aresetn, ce, rs485_rxd, rs485_txd, rs485_de, relay_a, relay_b;
	logic        gap_alert, de_seen, ok, ah, wh, bh, dn;
	logic [7:0]  b;
	logic [7:0]  q[$];
	logic [15:0] c;
	int          failures, n_checks, cyc;

	mbs_slave #(.SEC_CYC(SEC), .ID_CODE(IDV)) mbs_slave_inst (.aclk, .aresetn, .ce,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .rs485_rxd, .rs485_txd, .rs485_de, .relay_a,
		.relay_b, .gap_alert);
	mbs_master_model mbs_master_model_inst (.aclk, .rxd(rs485_rxd), .txd(rs485_txd),
		.de(rs485_de));

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// watchdog and driver activity monitor
	always @(posedge aclk) begin
		cyc++;
		if (rs485_de)
			de_seen <= 1'b1;
		if (cyc == 400_000) begin
			failures++;
			results();
		end
	end

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		dn = 1'b0;
		while (!dn) begin
			@(negedge aclk);
			ah = s_axi_awvalid & s_axi_awready;
			wh = s_axi_wvalid & s_axi_wready;
			bh = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge aclk);
			if (ah)
				s_axi_awvalid <= 1'b0;
			if (wh)
				s_axi_wvalid <= 1'b0;
			if (bh) begin
				s_axi_bready <= 1'b0;
				dn = 1'b1;
			end
		end
	endtask

	task automatic axi_rd(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		dn = 1'b0;
		while (!dn) begin
			@(negedge aclk);
			ah = s_axi_arvalid & s_axi_arready;
			bh = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge aclk);
			if (ah)
				s_axi_arvalid <= 1'b0;
			if (bh) begin
				s_axi_rready <= 1'b0;
				dn = 1'b1;
			end
		end
	endtask

	task automatic results;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		ce = 1'b1;
		de_seen = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		// register defaults, identity, unmapped place, rate change
		axi_rd(A_CTRL);
		`CHK("ctrl reset", CTRL_RST, rd)
		axi_rd(A_ID);
		`CHK("id", {16'h0000, IDV}, rd)
		axi_rd(12'h010);
		`CHK("unmapped rd", REPLY_EXTRA_DELAY_ERR, rsp)
		axi_wr(12'h020, 32'h0000_0001);
		`CHK("unmapped wr", REPLY_EXTRA_DELAY_ERR, rsp)
		axi_wr(A_CTRL, 32'h0001_0007);
		axi_rd(A_CTRL);
		`CHK("rate 115200", 32'h0001_0007, rd)
		axi_wr(12'h114, 32'h0000_fff6);
		$display("test registers done");
		// broadcast single write sets the relays but stays silent
		de_seen = 1'b0;
		q = {BCAST, FN_WR1, 8'h00, 8'h04, 8'h00, 8'h03};
		mbs_master_model_inst.send(q);
		repeat (60 * BIT) @(posedge aclk);
		`CHK("broadcast silent", 1'b0, de_seen)
		`CHK("relay a", 1'b1, relay_a)
		`CHK("relay b", 1'b1, relay_b)
		axi_rd(12'h110);
		`CHK("reg 04h", 32'h0000_0003, rd)
		$display("test broadcast done");
		// group read of a positive and a negative word, two registers asked
		q = {8'h01, FN_RD, 8'h00, 8'h04, 8'h00, 8'h02};
		mbs_master_model_inst.send(q);
		q = {8'h01, FN_RD, 8'h04, 8'h00, 8'h03, 8'hff, 8'hf6};
		c = mbs_master_model_inst.crc_of(q);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i]) begin
			mbs_master_model_inst.get_byte(b, ok);
			`CHK("reply byte", q[i], b)
			`CHK("stop bits", 1'b1, ok)
		end
		$display("test group read done");
		// gap timeout: clamp, then expiry forces the relays off
		`CHK("gap off", 1'b0, gap_alert)
		axi_wr(A_GAP, 32'h0000_00c8);
		axi_rd(A_GAP);
		`CHK("gap clamp", {25'h0, GAP_MAX_S}, rd)
		axi_wr(A_GAP, 32'h0000_0001);
		repeat (3 * SEC) @(posedge aclk);
		`CHK("gap alert", 1'b1, gap_alert)
		`CHK("relay forced", 1'b0, relay_a)
		axi_rd(A_STAT);
		`CHK("stat alert", 1'b1, rd[0])
		$display("test gap done");
		results();
	end
endmodule
`default_nettype wire
